// ===== verilog/pwm_input_stage.v
// PWM input stage with shoot-through guard, ready line, strap and oscillator monitor
`include "pwm_guard_defines.vh"

module pwm_input_stage #(
    parameter [15:0] DT_UNIT   = `DT_UNIT_CYC,
    parameter [15:0] INIT_CYC  = `INIT_CYC,
    parameter [15:0] REF_NOM   = `REF_NOM_CYC,
    parameter [15:0] REF_TOL   = `REF_TOL_CYC,
    parameter [15:0] SEC_NOM   = `SEC_NOM_EDGES,
    parameter [15:0] SEC_TOL   = `SEC_TOL_EDGES
) (
    input  wire               aclk,
    input  wire               aresetn,
    // AXI4-Lite slave
    input  wire [`ADDR_W-1:0] awaddr,
    input  wire               awvalid,
    output wire               awready,
    input  wire [31:0]        wdata,
    input  wire [3:0]         wstrb,
    input  wire               wvalid,
    output wire               wready,
    output reg  [1:0]         bresp,
    output reg                bvalid,
    input  wire               bready,
    input  wire [`ADDR_W-1:0] araddr,
    input  wire               arvalid,
    output wire               arready,
    output reg  [31:0]        rdata,
    output reg  [1:0]         rresp,
    output reg                rvalid,
    input  wire               rready,
    // Pins from the controller
    input  wire               pwm_in,
    input  wire               shoot_guard_in,
    input  wire               enable_in,
    input  wire               enable_valid_in,
    input  wire               guard_valid_in,
    input  wire               reset_ready_line_in,
    output wire               reset_ready_line_out,
    output wire               reset_ready_line_oe,
    input  wire               debug_strap_in,
    // Oscillator monitor inputs
    input  wire               ref_tick_toggle,
    input  wire               sec_osc_toggle,
    // Toward the secondary chip
    output reg                turn_on_cmd,
    output reg                turn_off_cmd,
    output reg                start_stop_osc_run,
    output reg                class_b_fail,
    output reg                debug_mode
);

    // Synchronised pins
    wire [8:0] pins_s;
    wire       pwm_s;
    wire       guard_s;
    wire       en_s;
    wire       en_valid_s;
    wire       guard_valid_s;
    wire       line_s;
    wire       strap_s;
    wire       ref_s;
    wire       sec_s;

    sync_two_ff #(
        .W        (9)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({sec_osc_toggle, ref_tick_toggle, debug_strap_in,
                    reset_ready_line_in, guard_valid_in, enable_valid_in,
                    enable_in, shoot_guard_in, pwm_in}),
        .sync_out (pins_s)
    );

    assign pwm_s         = pins_s[0];
    assign guard_s       = pins_s[1];
    assign en_s          = pins_s[2];
    assign en_valid_s    = pins_s[3];
    assign guard_valid_s = pins_s[4];
    assign line_s        = pins_s[5];
    assign strap_s       = pins_s[6];
    assign ref_s         = pins_s[7];
    assign sec_s         = pins_s[8];

    // Ready line driver and external reset detection
    reg  [15:0] init_cnt_q;
    reg  [2:0]  oe_hist_q;
    reg         ext_rst_q;
    wire        drive_low = (init_cnt_q != 16'h0000);
    wire        ext_low   = !line_s && !drive_low && (oe_hist_q == 3'h0);
    wire        rst       = !aresetn || ext_rst_q;

    // Own pull-down echoes back through the synchroniser, so it is masked
    always @(posedge aclk) begin
        if (!aresetn) begin
            oe_hist_q <= 3'h7;
            ext_rst_q <= 1'b0;
        end else begin
            oe_hist_q <= {oe_hist_q[1:0], drive_low};
            ext_rst_q <= ext_low;
        end
    end

    // Hold the line low until the primary side has settled
    always @(posedge aclk) begin
        if (rst) begin
            init_cnt_q <= INIT_CYC;
        end else if (drive_low) begin
            init_cnt_q <= init_cnt_q - 16'h0001;
        end
    end

    assign reset_ready_line_out = 1'b0;
    assign reset_ready_line_oe  = drive_low;

    // Debug strap caught once after power-up release
    reg strap_taken_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            strap_taken_q <= 1'b0;
            debug_mode    <= 1'b0;
        end else if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            debug_mode    <= strap_s;
        end
    end

    // Configuration
    reg [`CFG_DT_W-1:0] cfg_dt_q;

    // Guard window: pulse plus (field + 1) dead time units
    reg  [15:0] dt_cnt_q;
    wire [31:0] dt_prod = ({28'h0000000, cfg_dt_q} + 32'h00000001) * {16'h0000, DT_UNIT};
    wire [15:0] dt_load = dt_prod[15:0];
    wire        inhibit = guard_s || (dt_cnt_q != 16'h0000);

    always @(posedge aclk) begin
        if (rst) begin
            dt_cnt_q <= 16'h0000;
        end else if (guard_s) begin
            dt_cnt_q <= dt_load;
        end else if (dt_cnt_q != 16'h0000) begin
            dt_cnt_q <= dt_cnt_q - 16'h0001;
        end
    end

    // Switch command
    wire en_ok   = en_s && en_valid_s;
    wire cmd_q   = turn_on_cmd;
    wire start   = pwm_s && en_ok && guard_valid_s && !cmd_q;
    wire blocked = start && inhibit;
    reg  blocked_q;
    reg  cmd_d;

    // Level-sensitive start, so a briefly blocked edge only delays turn-on
    always @* begin
        cmd_d = 1'b0;
        if (!pwm_s || !en_ok) begin
            cmd_d = 1'b0;
        end else if (cmd_q) begin
            cmd_d = 1'b1;
        end else if (guard_valid_s && !inhibit) begin
            cmd_d = 1'b1;
        end
    end

    always @(posedge aclk) begin
        if (rst) begin
            turn_on_cmd        <= 1'b0;
            turn_off_cmd       <= 1'b1;
            start_stop_osc_run <= 1'b0;
            blocked_q          <= 1'b0;
        end else begin
            turn_on_cmd        <= cmd_d;
            turn_off_cmd       <= !cmd_d;
            start_stop_osc_run <= cmd_d;
            blocked_q          <= blocked;
        end
    end

    // Flag only a block seen on two consecutive samples
    wire viol_set = blocked && blocked_q;

    // Oscillator monitor against an independent reference tick
    reg         ref_d_q;
    reg         sec_d_q;
    reg         armed_q;
    reg  [15:0] cyc_cnt_q;
    reg  [15:0] sec_cnt_q;
    wire        ref_edge = ref_s ^ ref_d_q;
    wire        sec_edge = sec_s ^ sec_d_q;
    wire        cyc_lo   = cyc_cnt_q < (REF_NOM - REF_TOL);
    wire        cyc_hi   = cyc_cnt_q > (REF_NOM + REF_TOL);
    wire        sec_bad  = (sec_cnt_q < (SEC_NOM - SEC_TOL)) ||
                           (sec_cnt_q > (SEC_NOM + SEC_TOL));
    wire        primary_rc_osc_set = armed_q && ((ref_edge && cyc_lo) || cyc_hi);
    wire        secondary_rc_osc_set = armed_q && ref_edge && sec_bad;

    // Counts saturate; a lost reference shows as primary overrun
    always @(posedge aclk) begin
        if (rst) begin
            ref_d_q   <= ref_s; // No false edge when a line reset lifts
            sec_d_q   <= sec_s;
            armed_q   <= 1'b0;
            cyc_cnt_q <= 16'h0000;
            sec_cnt_q <= 16'h0000;
        end else begin
            ref_d_q <= ref_s;
            sec_d_q <= sec_s;
            if (ref_edge) begin
                armed_q   <= 1'b1;
                cyc_cnt_q <= 16'h0000;
                sec_cnt_q <= 16'h0000;
            end else begin
                if (cyc_cnt_q != 16'hFFFF) begin
                    cyc_cnt_q <= cyc_cnt_q + 16'h0001;
                end
                if (sec_edge && sec_cnt_q != 16'hFFFF) begin
                    sec_cnt_q <= sec_cnt_q + 16'h0001;
                end
            end
        end
    end

    // AXI4-Lite write path
    reg  [`ADDR_W-1:0] aw_addr_q;
    reg                aw_held_q;
    reg  [31:0]        w_data_q;
    reg  [3:0]         w_strb_q;
    reg                w_held_q;
    wire               do_write = aw_held_q && w_held_q && !bvalid;
    wire               wr_err   = do_write && (aw_addr_q == `REG_ERROR) && w_strb_q[0];

    assign awready = !aw_held_q && !bvalid;
    assign wready  = !w_held_q && !bvalid;
    assign arready = !rvalid;

    // Bus channels stay on aresetn so a ready-line reset cannot break a beat
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= {`ADDR_W{1'b0}};
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid    <= 1'b1;
                case (aw_addr_q)
                    `REG_CONFIG, `REG_STATUS, `REG_ERROR: bresp <= `RESP_OKAY;
                    default: bresp <= `RESP_SLVERR;
                endcase
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Config register
    always @(posedge aclk) begin
        if (rst) begin
            cfg_dt_q <= `CFG_DT_RST;
        end else if (do_write && aw_addr_q == `REG_CONFIG && w_strb_q[0]) begin
            cfg_dt_q <= w_data_q[`CFG_DT_LSB +: `CFG_DT_W];
        end
    end

    // Sticky error flags: set wins over a write-one clear
    reg viol_q;
    reg primary_rc_osc_q;
    reg secondary_rc_osc_q;

    always @(posedge aclk) begin
        if (rst) begin
            viol_q       <= 1'b0;
            primary_rc_osc_q       <= 1'b0;
            secondary_rc_osc_q       <= 1'b0;
            class_b_fail <= 1'b0;
        end else begin
            viol_q <= viol_set || (viol_q && !(wr_err && w_data_q[`ER_GUARD]));
            primary_rc_osc_q <= primary_rc_osc_set || (primary_rc_osc_q && !(wr_err && w_data_q[`ER_PRIMARY_RC_OSC]));
            secondary_rc_osc_q <= secondary_rc_osc_set || (secondary_rc_osc_q && !(wr_err && w_data_q[`ER_SECONDARY_RC_OSC]));
            class_b_fail <= primary_rc_osc_set || secondary_rc_osc_set ||
                            ((primary_rc_osc_q || secondary_rc_osc_q) && !(wr_err &&
                             (w_data_q[`ER_PRIMARY_RC_OSC] || w_data_q[`ER_SECONDARY_RC_OSC]) &&
                             !(primary_rc_osc_q && !w_data_q[`ER_PRIMARY_RC_OSC]) &&
                             !(secondary_rc_osc_q && !w_data_q[`ER_SECONDARY_RC_OSC])));
        end
    end

    // Read data mux
    reg [31:0] rd_mux;
    reg        rd_ok;

    always @* begin
        rd_mux = 32'h00000000;
        rd_ok  = 1'b1;
        case (araddr)
            `REG_CONFIG: rd_mux[`CFG_DT_LSB +: `CFG_DT_W] = cfg_dt_q;
            `REG_STATUS: begin
                rd_mux[`ST_GUARD]  = inhibit;
                rd_mux[`ST_CMD]    = turn_on_cmd;
                rd_mux[`ST_DEBUG]  = debug_mode;
                rd_mux[`ST_READY]  = !drive_low;
                rd_mux[`ST_CLASSB] = class_b_fail;
            end
            `REG_ERROR: begin
                rd_mux[`ER_GUARD] = viol_q;
                rd_mux[`ER_PRIMARY_RC_OSC]  = primary_rc_osc_q;
                rd_mux[`ER_SECONDARY_RC_OSC]  = secondary_rc_osc_q;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    // AXI4-Lite read path, one cycle to answer
    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_mux;
            rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule

// ===== verilog/pwm_guard_defines.vh
// Constants for the PWM input stage with shoot-through guard
`ifndef PWM_GUARD_DEFINES_VH
`define PWM_GUARD_DEFINES_VH

// Register byte offsets
`define ADDR_W          4
`define REG_CONFIG      4'h0
`define REG_STATUS      4'h4
`define REG_ERROR       4'h8

// Config fields
`define CFG_DT_LSB      0
`define CFG_DT_W        4
`define CFG_DT_RST      4'h2

// Status bit positions
`define ST_GUARD        0
`define ST_CMD          1
`define ST_DEBUG        2
`define ST_READY        3
`define ST_CLASSB       4

// Error bit positions, write one to clear
`define ER_GUARD        0
`define ER_PRIMARY_RC_OSC         1
`define ER_SECONDARY_RC_OSC         2

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// Timing
`define CLK_PERIOD_NS   50
`define DT_UNIT_NS      200
`define INIT_NS         1000
`define DT_UNIT_CYC     ((`DT_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_CYC        (`INIT_NS / `CLK_PERIOD_NS)

// Oscillator monitor window, per reference period
`define REF_NOM_CYC     1000
`define REF_TOL_CYC     50
`define SEC_NOM_EDGES   500
`define SEC_TOL_EDGES   25

`endif

// ===== verilog/sync_two_ff.v
// Two flip-flop synchroniser for a group of asynchronous levels
module sync_two_ff #(
    parameter W = 1
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First stage is read only by the second stage
    // No reset, so a strapped level is already through both stages when reset lifts
    always @(posedge aclk) begin
        meta_q <= async_in;
        sync_q <= meta_q;
    end

    assign sync_out = sync_q;

endmodule

// ===== tb/pwm_input_stage_checker.sv
// Port-level checks for the PWM input stage
module pwm_input_stage_checker (
    input wire       aclk,
    input wire       aresetn,
    input wire       pwm_in,
    input wire       shoot_guard_in,
    input wire       enable_in,
    input wire       enable_valid_in,
    input wire       guard_valid_in,
    input wire       reset_ready_line_oe,
    input wire       debug_mode,
    input wire       turn_on_cmd,
    input wire       turn_off_cmd,
    input wire       start_stop_osc_run,
    input wire       bvalid,
    input wire       bready,
    input wire [1:0] bresp,
    input wire       class_b_fail
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Pins reach the command three edges later
    off_compl_a: assert property (turn_off_cmd == !turn_on_cmd)
        else $error("turn-off not inverse of turn-on");
    osc_run_a: assert property (start_stop_osc_run == turn_on_cmd)
        else $error("start-stop run differs from command");
    pwm_low_a: assert property (!$past(pwm_in, 3) |-> !turn_on_cmd)
        else $error("turn-on with pwm low");
    en_off_a: assert property (!($past(enable_in, 3) && $past(enable_valid_in, 3))
        |-> !turn_on_cmd) else $error("turn-on with enable invalid");
    rise_free_a: assert property ($rose(turn_on_cmd) |-> $past(pwm_in, 3)
        && $past(guard_valid_in, 3) && !$past(shoot_guard_in, 3))
        else $error("turn-on started in guard window");
    // Guard never cuts a running turn-on
    on_hold_a: assert property (turn_on_cmd && $past(pwm_in, 2) && $past(enable_in, 2)
        && $past(enable_valid_in, 2) |=> turn_on_cmd) else $error("turn-on dropped");
    ready_rel_a: assert property ($rose(aresetn) |->
        reset_ready_line_oe ##[1:8] !reset_ready_line_oe) else $error("ready line stuck");
    strap_hold_a: assert property ($past(aresetn, 2) |-> $stable(debug_mode))
        else $error("debug mode changed after power-up");
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response not held");
    cover property ($rose(turn_on_cmd));
    cover property (turn_on_cmd && shoot_guard_in);
    cover property ($rose(class_b_fail));
endmodule

bind pwm_input_stage pwm_input_stage_checker chk_u (.aclk, .aresetn, .pwm_in,
    .shoot_guard_in, .enable_in, .enable_valid_in, .guard_valid_in, .reset_ready_line_oe,
    .debug_mode, .turn_on_cmd, .turn_off_cmd, .start_stop_osc_run, .bvalid, .bready,
    .bresp, .class_b_fail);

// ===== tb/host_ctrl_model.sv
// Host controller model: pwm, guard, enable pins and the ready line
module host_ctrl_model #(
    parameter int SETTLE = 3
) (
    input  logic aclk,
    input  logic pwm_req,
    input  logic guard_req,
    input  logic en_req,
    input  logic rst_req,
    input  logic reset_ready_line_oe,
    output logic pwm_in = 1'h0,
    output logic shoot_guard_in = 1'h0,
    output logic enable_in = 1'h0,
    output logic reset_ready_line_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] settle_q = 4'h0;
    // A new pwm rise waits until enable has settled
    always @(posedge aclk) begin
        enable_in <= en_req;
        settle_q <= !enable_in ? 4'h0 : (settle_q == SETTLE) ? settle_q : settle_q + 4'h1;
        pwm_in <= pwm_req && (pwm_in || settle_q == SETTLE);
        shoot_guard_in <= guard_req;
    end
    // Open drain with pull-up: low if either side pulls
    assign reset_ready_line_in = !(reset_ready_line_oe || rst_req);
endmodule

// ===== tb/tb_pwm_input_stage.sv
// Self-checking bench for the PWM input stage
`include "pwm_guard_defines.vh"
module tb_pwm_input_stage;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, seed = 32'h4816, rdata;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        pwm_req = 1'h0, guard_req = 1'h0, en_req = 1'h0, rst_req = 1'h0;
    logic        enable_valid_in = 1'h0, guard_valid_in = 1'h0, debug_strap_in = 1'h1;
    logic        ref_tick_toggle = 1'h0, sec_osc_toggle = 1'h0, osc_on = 1'h1;
    logic        pwm_in, shoot_guard_in, enable_in, reset_ready_line_in;
    logic        reset_ready_line_out, reset_ready_line_oe;
    logic        turn_on_cmd, turn_off_cmd, start_stop_osc_run, class_b_fail, debug_mode;
    logic [5:0]  cyc = 6'h0;
    logic [1:0]  qb[$];
    logic [33:0] qr[$];
    int          err_total = 0, checks_done = 0;

    pwm_input_stage #(.DT_UNIT(16'h1), .INIT_CYC(16'h4), .REF_NOM(16'h28), .REF_TOL(16'h4),
        .SEC_NOM(16'h14), .SEC_TOL(16'h2)) dut_u (.*);
    host_ctrl_model host_u (.*);

    always #25 aclk = ~aclk;

    // Reference period 40 cycles, secondary toggles 20 times in it
    always @(posedge aclk) begin
        cyc <= (cyc == 6'h27) ? 6'h0 : cyc + 6'h1;
        if (osc_on && cyc == 6'h27) ref_tick_toggle <= ~ref_tick_toggle;
        if (cyc[0]) sec_osc_toggle <= ~sec_osc_toggle;
    end

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Bus answers are matched to the oldest note
    always @(posedge aclk) begin
        if (bvalid && bready && qb.size() > 0) chk("bresp", 34'(qb.pop_front()), 34'(bresp));
        if (rvalid && rready && qr.size() > 0) chk("read", qr.pop_front(), {rresp, rdata});
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic pick(input int k);
        return k == 0 ? turn_on_cmd : k == 1 ? class_b_fail : reset_ready_line_oe;
    endfunction

    // Bounded wait for an output level; a timeout ends the run
    task automatic wt(input int k, input logic v, input int lim);
        int n;
        for (n = 0; n < lim && pick(k) !== v; n++) @(posedge aclk);
        chk("output level", 34'(v), 34'(pick(k)));
        if (pick(k) !== v) end_sim();
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        qb.push_back(e);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        bready <= 1'h0;
        chk("write done", 34'h1, 34'(n < 40));
        if (n == 40) end_sim();
        @(posedge aclk); // Next call must not reassign bready in this step
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        qr.push_back({e, d});
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rready <= 1'h0;
        chk("read done", 34'h1, 34'(n < 40));
        if (n == 40) end_sim();
        @(posedge aclk); // Next call must not reassign rready in this step
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        wt(2, 1'h0, 40);
        chk("line drive level", 34'h0, 34'(reset_ready_line_out));
        debug_strap_in <= 1'h0;
        rd(`REG_CONFIG, 32'h2, `RESP_OKAY);
        rd(`REG_STATUS, 32'hC, `RESP_OKAY);
        rd(4'hC, 32'h0, `RESP_SLVERR);
        wr(4'hC, 32'h7, `RESP_SLVERR);
        wr(`REG_STATUS, 32'hF, `RESP_OKAY);
        wstrb <= 4'hE;
        wr(`REG_CONFIG, 32'h9, `RESP_OKAY);
        wstrb <= 4'hF;
        rd(`REG_CONFIG, 32'h2, `RESP_OKAY);
        wr(`REG_CONFIG, 32'h1, `RESP_OKAY);
        en_req <= 1'h1;
        enable_valid_in <= 1'h1;
        guard_valid_in <= 1'h1;
        pwm_req <= 1'h1;
        wt(0, 1'h1, 40);
        guard_req <= 1'h1;
        repeat (6) @(posedge aclk);
        chk("held on", 34'h1, 34'(turn_on_cmd));
        rd(`REG_STATUS, 32'hF, `RESP_OKAY);
        pwm_req <= 1'h0;
        wt(0, 1'h0, 20);
        pwm_req <= 1'h1;
        repeat (8) @(posedge aclk);
        chk("blocked", 34'h0, 34'(turn_on_cmd));
        rd(`REG_ERROR, 32'h1, `RESP_OKAY);
        guard_req <= 1'h0;
        repeat (5) @(posedge aclk);
        chk("dead time", 34'h0, 34'(turn_on_cmd));
        wt(0, 1'h1, 20);
        rd(`REG_STATUS, 32'hE, `RESP_OKAY);
        wr(`REG_ERROR, 32'h1, `RESP_OKAY);
        rd(`REG_ERROR, 32'h0, `RESP_OKAY);
        enable_valid_in <= 1'h0;
        wt(0, 1'h0, 20);
        repeat (80) begin
            seed = xs(seed);
            pwm_req <= seed[0];
            guard_req <= seed[1];
            en_req <= |seed[3:2];
            enable_valid_in <= |seed[5:4];
            guard_valid_in <= |seed[7:6];
            repeat (int'(seed[10:8]) + 1) @(posedge aclk);
        end
        pwm_req <= 1'h0;
        guard_req <= 1'h0;
        wt(0, 1'h0, 20);
        repeat (10) @(posedge aclk);
        wr(`REG_ERROR, 32'h7, `RESP_OKAY);
        osc_on <= 1'h0;
        wt(1, 1'h1, 150);
        rd(`REG_ERROR, 32'h2, `RESP_OKAY);
        rd(`REG_STATUS, 32'h1C, `RESP_OKAY);
        osc_on <= 1'h1;
        repeat (120) @(posedge aclk);
        wr(`REG_ERROR, 32'h7, `RESP_OKAY);
        rd(`REG_ERROR, 32'h0, `RESP_OKAY);
        chk("class b", 34'h0, 34'(class_b_fail));
        wr(`REG_CONFIG, 32'h5, `RESP_OKAY);
        rst_req <= 1'h1;
        repeat (8) @(posedge aclk);
        chk("pull low", 34'h1, 34'(reset_ready_line_oe));
        rst_req <= 1'h0;
        wt(2, 1'h0, 40);
        rd(`REG_CONFIG, 32'h2, `RESP_OKAY);
        rd(`REG_STATUS, 32'hC, `RESP_OKAY);
        end_sim();
    end
endmodule
